// file: include/eeio_pkg.sv
// Constants, types and layouts for the EEPROM access and I/O space block
package eeio_pkg;

  localparam int unsigned EE_AW    = 9;
  localparam int unsigned EE_DEPTH = 512;
  localparam int unsigned IO_AW    = 6;
  localparam int unsigned APB_AW   = 12;

  // APB window regions, selected by paddr[11:10]
  localparam logic [1:0] REG_DIRECT = 2'h0;
  localparam logic [1:0] REG_DSPACE = 2'h1;
  localparam logic [1:0] REG_BITOP  = 2'h2;

  // I/O space limits
  localparam logic [6:0] DS_IO_BASE  = 7'h20;
  localparam logic [6:0] DS_IO_LAST  = 7'h5f;
  localparam logic [5:0] IO_BIT_LAST = 6'h1f;

  // I/O addresses of the block registers
  localparam logic [5:0] IO_EE_STAT = 6'h1b;
  localparam logic [5:0] IO_EE_CTRL = 6'h1c;
  localparam logic [5:0] IO_EE_DATA = 6'h1d;
  localparam logic [5:0] IO_EE_ADRL = 6'h1e;
  localparam logic [5:0] IO_EE_ADRH = 6'h1f;

  // Bit positions in eeprom_control and status
  localparam int unsigned CTRL_RE   = 0;
  localparam int unsigned CTRL_WE   = 1;
  localparam int unsigned CTRL_MWE  = 2;
  localparam int unsigned CTRL_RIE  = 3;
  localparam int unsigned STAT_DONE = 0;

  // Bit-operation command word fields
  localparam int unsigned BOP_BIT_LSB = 8;
  localparam int unsigned BOP_OP_LSB  = 16;

  // Cycle counts
  localparam logic [2:0] MWE_HOLD = 3'h4;
  localparam logic [2:0] HALT_RD  = 3'h4;
  localparam logic [2:0] HALT_WR  = 3'h2;
  localparam int unsigned WR_RC_CYCLES = 8448;
  localparam int unsigned WR_CNT_W     = 14;

  // Values after reset
  localparam logic [8:0] ADDR_RST = 9'h000;
  localparam logic [7:0] DATA_RST = 8'h00;

  typedef enum logic [1:0] {
    BOP_SET  = 2'h0,
    BOP_CLR  = 2'h1,
    BOP_TEST = 2'h2
  } eeio_bitop_e;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'b01,
    ENG_PROG = 2'b10
  } eeio_eng_e;

  typedef struct packed {
    logic       en;
    logic [5:0] addr;
    logic [7:0] data;
  } eeio_iowr_s;

  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] data;
  } eeio_wreq_s;

endpackage : eeio_pkg

// file: rtl/eeio_wr_engine.sv
// Timed EEPROM byte-write engine, kept alive across bus reset
`timescale 1ns/1ps
module eeio_wr_engine #(
  parameter int unsigned WR_RC_CYCLES = eeio_pkg::WR_RC_CYCLES
) (
  input  wire logic                pclk,       // CPU clock
  input  wire logic                por_rst_n,  // Power-on reset, async
  input  wire logic                ce,         // Clock enable
  input  wire logic                rc_osc_clk, // Calibrated RC oscillator pin
  input  wire logic                start,      // Start one write
  input  eeio_pkg::eeio_wreq_s     req,        // Address and data to write
  output logic                     busy,       // Write in progress
  output logic                     done,       // Write finished pulse
  output eeio_pkg::eeio_wreq_s     wr          // Latched address and data
);

  localparam int unsigned CNT_W = eeio_pkg::WR_CNT_W;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(WR_RC_CYCLES - 1);

  logic                            rc_s1_q;
  logic                            rc_s2_q;
  logic                            rc_s3_q;
  logic                            tick;
  eeio_pkg::eeio_eng_e             state_q;
  logic [eeio_pkg::WR_CNT_W-1:0]   cnt_q;
  logic                            done_q;
  eeio_pkg::eeio_wreq_s            wr_q;

  // Oscillator pin synchroniser
  always_ff @(posedge pclk or negedge por_rst_n) begin
    if (!por_rst_n) begin
      rc_s1_q <= 1'b0;
      rc_s2_q <= 1'b0;
      rc_s3_q <= 1'b0;
    end else if (ce) begin
      rc_s1_q <= rc_osc_clk;
      rc_s2_q <= rc_s1_q;
      rc_s3_q <= rc_s2_q;
    end
  end

  assign tick = rc_s2_q & ~rc_s3_q;

  always_ff @(posedge pclk or negedge por_rst_n) begin
    if (!por_rst_n) begin
      state_q <= eeio_pkg::ENG_IDLE;
      cnt_q   <= '0;
      done_q  <= 1'b0;
      wr_q    <= '0;
    end else if (ce) begin
      done_q <= 1'b0;
      case (state_q)
        eeio_pkg::ENG_IDLE: begin
          if (start) begin
            state_q <= eeio_pkg::ENG_PROG;
            cnt_q   <= '0;
            wr_q    <= req;
          end
        end
        eeio_pkg::ENG_PROG: begin
          if (tick) begin
            if (cnt_q == LAST) begin
              state_q <= eeio_pkg::ENG_IDLE;
              done_q  <= 1'b1;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
        end
        default: state_q <= eeio_pkg::ENG_IDLE;
      endcase
    end
  end

  assign busy = (state_q == eeio_pkg::ENG_PROG);
  assign done = done_q;
  assign wr   = wr_q;

endmodule : eeio_wr_engine

// file: rtl/eeio_top.sv
// EEPROM access logic behind an APB view of the I/O register space
//
// Functional notes
// - Write continues through power-down entry
// - Oscillator kept running after such write
// - Reset does not abort a running write
// - Direct I/O addresses 0x00 to 0x3F
// - Data-space view adds 0x20 to address
// - Bit ops only on 0x00 to 0x1F
// - Flag clears on writing one
// - Bit ops rewrite whole register
// - Master enable clears after four cycles
// - Write strobe clears after 8448 RC cycles
// - Nine-bit address, upper high bits zero
// - CPU halted four after read, two after write
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module eeio_top #(
  parameter int unsigned WR_RC_CYCLES = eeio_pkg::WR_RC_CYCLES
) (
  input  wire logic        pclk,             // CPU clock, 50 MHz
  input  wire logic        presetn,          // Bus reset, async, active low
  input  wire logic        por_rst_n,        // Power-on reset for write engine
  input  wire logic        ce,               // Clock enable, freezes state
  input  wire logic        psel,             // APB select
  input  wire logic        penable,          // APB enable
  input  wire logic        pwrite,           // APB direction
  input  wire logic [11:0] paddr,            // APB byte address
  input  wire logic [31:0] pwdata,           // APB write data
  output logic             pready,           // APB ready
  output logic [31:0]      prdata,           // APB read data
  output logic             pslverr,          // APB error
  input  wire logic        rc_osc_clk,       // Calibrated RC oscillator pin
  input  wire logic        pd_req,           // Power-down sleep requested
  output logic             cpu_halt,         // Core halt after strobe
  output logic             osc_keep_running, // Oscillator held on
  output logic             pd_entered        // Power-down fully entered
);

  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic [8:0]  addr_q;
  logic [7:0]  data_q;
  logic        rie_q;
  logic [2:0]  mwe_cnt_q;
  logic        done_flag_q;
  logic        bit_test_q;
  logic [2:0]  halt_cnt_q;
  logic [2:0]  halt_d;
  logic        cpu_halt_q;
  logic        pd_req_q;
  logic        pd_wr_q;
  logic        osc_keep_q;
  logic        pd_entered_q;
  logic [7:0]  mem [eeio_pkg::EE_DEPTH];

  logic                 busy;
  logic                 done;
  eeio_pkg::eeio_wreq_s wr;
  eeio_pkg::eeio_wreq_s wreq;
  eeio_pkg::eeio_iowr_s iowr;

  logic [1:0]  region;
  logic [6:0]  ds_idx;
  logic [5:0]  io_idx;
  logic        hit;
  logic        acc;
  logic [5:0]  bop_addr;
  logic [2:0]  bop_bit;
  logic [1:0]  bop_op;
  logic [7:0]  bop_rd;
  logic [7:0]  ctrl_rd;
  logic [7:0]  stat_rd;
  logic [31:0] rd_word;
  logic        ctl_wr;
  logic        wr_start;
  logic        rd_start;

  // Byte read of one I/O register; unmapped addresses read zero
  function automatic logic [7:0] io_read(
    input logic [5:0] idx,
    input logic [8:0] adr,
    input logic [7:0] dat,
    input logic [7:0] ctl,
    input logic [7:0] sts
  );
    logic [7:0] r;
    r = 8'h00;
    case (idx)
      eeio_pkg::IO_EE_ADRH: r = {7'h00, adr[8]};
      eeio_pkg::IO_EE_ADRL: r = adr[7:0];
      eeio_pkg::IO_EE_DATA: r = dat;
      eeio_pkg::IO_EE_CTRL: r = ctl;
      eeio_pkg::IO_EE_STAT: r = sts;
      default:              r = 8'h00;
    endcase
    return r;
  endfunction : io_read

  eeio_wr_engine #(
    .WR_RC_CYCLES (WR_RC_CYCLES)
  ) u_engine (
    .pclk       (pclk),
    .por_rst_n  (por_rst_n),
    .ce         (ce),
    .rc_osc_clk (rc_osc_clk),
    .start      (wr_start),
    .req        (wreq),
    .busy       (busy),
    .done       (done),
    .wr         (wr)
  );

  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[eeio_pkg::CTRL_RIE] = rie_q;
    ctrl_rd[eeio_pkg::CTRL_MWE] = (mwe_cnt_q != 3'h0);
    ctrl_rd[eeio_pkg::CTRL_WE]  = busy;
    stat_rd = 8'h00;
    stat_rd[eeio_pkg::STAT_DONE] = done_flag_q;
  end

  // Address decode and I/O write source
  always_comb begin
    region   = paddr[11:10];
    ds_idx   = paddr[8:2];
    io_idx   = paddr[7:2];
    bop_addr = pwdata[5:0];
    bop_bit  = pwdata[eeio_pkg::BOP_BIT_LSB +: 3];
    bop_op   = pwdata[eeio_pkg::BOP_OP_LSB +: 2];
    bop_rd   = io_read(bop_addr, addr_q, data_q, ctrl_rd, stat_rd);
    acc      = psel & penable & pready_q;
    hit      = 1'b0;
    rd_word  = 32'h0000_0000;
    iowr     = '0;
    case (region)
      eeio_pkg::REG_DIRECT: begin
        hit     = (paddr[9:8] == 2'h0);
        rd_word = {24'h000000, io_read(io_idx, addr_q, data_q, ctrl_rd, stat_rd)};
      end
      eeio_pkg::REG_DSPACE: begin
        hit     = ~paddr[9] && (ds_idx >= eeio_pkg::DS_IO_BASE) &&
                  (ds_idx <= eeio_pkg::DS_IO_LAST);
        io_idx  = 6'(ds_idx - eeio_pkg::DS_IO_BASE);
        rd_word = {24'h000000, io_read(io_idx, addr_q, data_q, ctrl_rd, stat_rd)};
      end
      eeio_pkg::REG_BITOP: begin
        hit     = (paddr[9:2] == 8'h00) &&
                  (!pwrite || ((bop_addr <= eeio_pkg::IO_BIT_LAST) && (bop_op != 2'h3)));
        rd_word = {31'h0000_0000, bit_test_q};
      end
      default: hit = 1'b0;
    endcase
    if (acc && pwrite && hit) begin
      if (region != eeio_pkg::REG_BITOP) begin
        iowr.en   = 1'b1;
        iowr.addr = io_idx;
        iowr.data = pwdata[7:0];
      end else if (bop_op != eeio_pkg::BOP_TEST) begin
        iowr.en   = 1'b1;
        iowr.addr = bop_addr;
        iowr.data = (bop_op == eeio_pkg::BOP_SET) ? (bop_rd | (8'h01 << bop_bit)) :
                                                    (bop_rd & ~(8'h01 << bop_bit));
      end
    end
  end

  assign ctl_wr   = iowr.en && (iowr.addr == eeio_pkg::IO_EE_CTRL);
  assign wr_start = ctl_wr && iowr.data[eeio_pkg::CTRL_WE] && (mwe_cnt_q != 3'h0) && !busy;
  assign rd_start = ctl_wr && iowr.data[eeio_pkg::CTRL_RE] && !busy;
  assign wreq     = '{addr: addr_q, data: data_q};

  // APB slave, one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q   <= 1'b0;
      prdata_q   <= 32'h0000_0000;
      pslverr_q  <= 1'b0;
      bit_test_q <= 1'b0;
    end else if (ce) begin
      if (psel && penable && !pready_q) begin
        pready_q  <= 1'b1;
        prdata_q  <= hit ? rd_word : 32'h0000_0000;
        pslverr_q <= ~hit;
      end else begin
        pready_q  <= 1'b0;
        pslverr_q <= 1'b0;
      end
      if (acc && pwrite && hit && region == eeio_pkg::REG_BITOP &&
          bop_op == eeio_pkg::BOP_TEST) begin
        bit_test_q <= bop_rd[bop_bit];
      end
    end
  end

  // Address held while a write runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= eeio_pkg::ADDR_RST;
    end else if (ce && iowr.en && !busy) begin
      if (iowr.addr == eeio_pkg::IO_EE_ADRH) begin
        addr_q[8] <= iowr.data[0];
      end else if (iowr.addr == eeio_pkg::IO_EE_ADRL) begin
        addr_q[7:0] <= iowr.data;
      end
    end
  end

  // Data byte, loaded by software or by a read strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_q <= eeio_pkg::DATA_RST;
    end else if (ce) begin
      if (rd_start) begin
        data_q <= mem[addr_q];
      end else if (iowr.en && iowr.addr == eeio_pkg::IO_EE_DATA) begin
        data_q <= iowr.data;
      end
    end
  end

  // Nonvolatile array
  always_ff @(posedge pclk) begin
    if (ce && done) begin
      mem[wr.addr] <= wr.data;
    end
  end

  // Control bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rie_q     <= 1'b0;
      mwe_cnt_q <= 3'h0;
    end else if (ce) begin
      if (ctl_wr) begin
        rie_q <= iowr.data[eeio_pkg::CTRL_RIE];
      end
      if (ctl_wr && iowr.data[eeio_pkg::CTRL_MWE]) begin
        mwe_cnt_q <= eeio_pkg::MWE_HOLD;
      end else if (mwe_cnt_q != 3'h0) begin
        mwe_cnt_q <= mwe_cnt_q - 3'h1;
      end
    end
  end

  // Write-done flag; a new completion beats a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_flag_q <= 1'b0;
    end else if (ce) begin
      if (done) begin
        done_flag_q <= 1'b1;
      end else if (iowr.en && iowr.addr == eeio_pkg::IO_EE_STAT &&
                   iowr.data[eeio_pkg::STAT_DONE]) begin
        done_flag_q <= 1'b0;
      end
    end
  end

  always_comb begin
    if (rd_start) begin
      halt_d = eeio_pkg::HALT_RD;
    end else if (wr_start) begin
      halt_d = eeio_pkg::HALT_WR;
    end else if (halt_cnt_q != 3'h0) begin
      halt_d = halt_cnt_q - 3'h1;
    end else begin
      halt_d = 3'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_cnt_q <= 3'h0;
      cpu_halt_q <= 1'b0;
    end else if (ce) begin
      halt_cnt_q <= halt_d;
      cpu_halt_q <= (halt_d != 3'h0);
    end
  end

  // Power-down entry with a write in flight
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_req_q     <= 1'b0;
      pd_wr_q      <= 1'b0;
      osc_keep_q   <= 1'b0;
      pd_entered_q <= 1'b0;
    end else if (ce) begin
      pd_req_q <= pd_req;
      if (!pd_req) begin
        pd_wr_q <= 1'b0;
      end else if (!pd_req_q && busy) begin
        pd_wr_q <= 1'b1;
      end
      if (!pd_req) begin
        osc_keep_q <= 1'b0;
      end else if (done && pd_wr_q) begin
        osc_keep_q <= 1'b1;
      end
      pd_entered_q <= pd_req && !busy && !pd_wr_q && !osc_keep_q;
    end
  end

  assign pready           = pready_q;
  assign prdata           = prdata_q;
  assign pslverr          = pslverr_q;
  assign cpu_halt         = cpu_halt_q;
  assign osc_keep_running = osc_keep_q;
  assign pd_entered       = pd_entered_q;

endmodule : eeio_top

// file: tb/eeio_top_assertions.sv
// Port-level checks for the EEPROM I/O block
`timescale 1ns/1ps
module eeio_top_assertions (
  input wire logic        pclk,             // Clock
  input wire logic        presetn,          // Reset
  input wire logic        psel,             // Select
  input wire logic        penable,          // Enable
  input wire logic        pwrite,           // Direction
  input wire logic [11:0] paddr,            // Address
  input wire logic [31:0] pwdata,           // Write data
  input wire logic        pready,           // Ready
  input wire logic [31:0] prdata,           // Read data
  input wire logic        pslverr,          // Error
  input wire logic        pd_req,           // Sleep request
  input wire logic        cpu_halt,         // Core halt
  input wire logic        osc_keep_running, // Oscillator on
  input wire logic        pd_entered        // Sleep entered
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic take;
  logic wtake;
  assign take  = psel && penable && pready;
  assign wtake = take && pwrite && (paddr == 12'h070 || paddr == 12'h800);

  property p_ready_wait;
    psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("ready timing wrong");
  property p_halt_len;
    $rose(cpu_halt) |-> (cpu_halt[*2] ##1 !cpu_halt) or (cpu_halt[*4] ##1 !cpu_halt);
  endproperty
  a_halt_len: assert property (p_halt_len) else $error("halt length wrong");
  property p_halt_cause;
    $rose(cpu_halt) |-> $past(wtake) || $past(wtake, 2);
  endproperty
  a_halt_cause: assert property (p_halt_cause) else $error("halt without strobe");
  property p_adrh;
    take && !pwrite && paddr == 12'h07c |-> prdata[31:1] == 31'h0;
  endproperty
  a_adrh: assert property (p_adrh) else $error("address high bits set");
  property p_direct;
    take && paddr[11:8] == 4'h0 |-> !pslverr;
  endproperty
  a_direct: assert property (p_direct) else $error("direct access refused");
  property p_dspace;
    take && paddr[11:10] == 2'h1 |-> pslverr == (paddr[9:2] < 8'h20 || paddr[9:2] > 8'h5f);
  endproperty
  a_dspace: assert property (p_dspace) else $error("data-space decode wrong");
  property p_bitop;
    take && pwrite && paddr == 12'h800 |->
      pslverr == (pwdata[5:0] > 6'h1f || pwdata[17:16] == 2'h3);
  endproperty
  a_bitop: assert property (p_bitop) else $error("bit-op range wrong");
  property p_keep_nopd;
    osc_keep_running |-> !pd_entered;
  endproperty
  a_keep_nopd: assert property (p_keep_nopd) else $error("sleep with oscillator on");
  property p_keep_hold;
    osc_keep_running && pd_req |=> osc_keep_running;
  endproperty
  a_keep_hold: assert property (p_keep_hold) else $error("oscillator dropped early");
  c_keep: cover property ($rose(osc_keep_running));
  c_err: cover property (take && pslverr);
  c_halt4: cover property (cpu_halt[*4]);
endmodule : eeio_top_assertions

bind eeio_top eeio_top_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .prdata, .pslverr, .pd_req, .cpu_halt, .osc_keep_running, .pd_entered);

// file: tb/eeio_cpu_model.sv
// CPU core model issuing I/O accesses over APB
`timescale 1ns/1ps
module eeio_cpu_model (
  input  wire logic        pclk,    // Clock
  input  wire logic        pready,  // Ready
  input  wire logic [31:0] prdata,  // Read data
  input  wire logic        pslverr, // Error
  output logic             psel,    // Select
  output logic             penable, // Enable
  output logic             pwrite,  // Direction
  output logic [11:0]      paddr,   // Address
  output logic [31:0]      pwdata   // Write data
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
  end

  // Call right after a rising edge; hold keeps select for a back-to-back transfer
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic hold, output logic [31:0] r, output logic e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    if (!hold) begin
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask : xfer

  task automatic io_wr(input logic [5:0] io, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, {4'h0, io, 2'b00}, d, 1'b0, r, e);
  endtask : io_wr

  task automatic io_rd(input logic [5:0] io, output logic [31:0] r);
    logic e;
    xfer(1'b0, {4'h0, io, 2'b00}, 32'h0, 1'b0, r, e);
  endtask : io_rd

  task automatic wait_idle;
    logic [31:0] r;
    r = 32'h2;
    while (r[1] === 1'b1) io_rd(6'h1c, r);
  endtask : wait_idle

  task automatic ee_write(input logic [8:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    wait_idle();
    io_wr(6'h1f, {31'h0, a[8]});
    io_wr(6'h1e, {24'h0, a[7:0]});
    io_wr(6'h1d, {24'h0, d});
    xfer(1'b1, 12'h070, 32'h4, 1'b1, r, e);
    xfer(1'b1, 12'h070, 32'h6, 1'b0, r, e);
  endtask : ee_write

  // strobe then data read at once
  task automatic ee_read(input logic [8:0] a, output logic [31:0] r);
    logic e;
    wait_idle();
    io_wr(6'h1f, {31'h0, a[8]});
    io_wr(6'h1e, {24'h0, a[7:0]});
    xfer(1'b1, 12'h070, 32'h1, 1'b1, r, e);
    io_rd(6'h1d, r);
  endtask : ee_read
endmodule : eeio_cpu_model

// file: tb/eeio_top_bench.sv
// Self-checking bench for the EEPROM I/O block
`timescale 1ns/1ps
module eeio_top_bench;
  localparam int unsigned WRC = 8;
  logic        pclk = 1'b0;
  logic        rc_osc_clk = 1'b0;
  logic        presetn, por_rst_n, pd_req, e, ce;
  logic        psel, penable, pwrite, pready, pslverr, cpu_halt, osc_keep_running, pd_entered;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [8:0]  a;
  logic [7:0]  d;
  int          mismatches, checks_done, cycles;
  int          mem[int];
  logic [11:0] eadr[4] = '{12'h440, 12'h580, 12'h800, 12'h800};
  logic [31:0] edat[4] = '{32'h0, 32'h0, 32'h20, 32'h3001e};

  always #10 pclk = ~pclk;
  always #47 rc_osc_clk = ~rc_osc_clk;

  eeio_top #(.WR_RC_CYCLES(WRC)) dut (.pclk, .presetn, .por_rst_n, .ce, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .rc_osc_clk, .pd_req, .cpu_halt,
    .osc_keep_running, .pd_entered);
  eeio_cpu_model u_cpu (.pclk, .pready, .prdata, .pslverr, .psel, .penable, .pwrite, .paddr,
    .pwdata);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      test_done();
    end
  end

  initial begin
    presetn = 1'b0;
    por_rst_n = 1'b0;
    pd_req = 1'b0;
    ce = 1'b1;
    void'($urandom(32'hcaa986f0));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    por_rst_n <= 1'b1;
    @(posedge pclk);
    u_cpu.io_rd(6'h1f, r);
    chk(r, 32'h0);
    u_cpu.io_rd(6'h1c, r);
    chk(r, 32'h0);
    $display("reset values done");
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 9'h000 : (i == 1) ? 9'h1ff : 9'($urandom_range(510, 1));
      d = 8'($urandom);
      mem[a] = d;
      u_cpu.ee_write(a, d);
      u_cpu.io_rd(6'h1c, r);
      chk(r & 32'h2, 32'h2);
      u_cpu.wait_idle();
    end
    u_cpu.io_wr(6'h1b, 32'h0);
    u_cpu.io_rd(6'h1b, r);
    chk(r, 32'h1);
    u_cpu.io_wr(6'h1b, 32'h1);
    u_cpu.io_rd(6'h1b, r);
    chk(r, 32'h0);
    foreach (mem[k]) begin
      u_cpu.ee_read(9'(k), r);
      chk(r, 32'(mem[k]));
    end
    $display("write and read done");
    u_cpu.io_wr(6'h1f, 32'h0);
    u_cpu.io_wr(6'h1e, 32'h0);
    u_cpu.io_wr(6'h1d, 32'(~mem[0] & 8'hff));
    u_cpu.io_wr(6'h1c, 32'h4);
    repeat (4) @(posedge pclk);
    u_cpu.io_wr(6'h1c, 32'h2);
    u_cpu.io_rd(6'h1c, r);
    chk(r, 32'h0);
    u_cpu.ee_read(9'h000, r);
    chk(r, 32'(mem[0]));
    $display("enable timeout done");
    // Frozen clock enable stretches the enable window
    u_cpu.io_wr(6'h1d, 32'(~mem[0] & 8'hff));
    mem[0] = ~mem[0] & 8'hff;
    u_cpu.io_wr(6'h1c, 32'h4);
    ce <= 1'b0;
    repeat (10) @(posedge pclk);
    ce <= 1'b1;
    u_cpu.io_wr(6'h1c, 32'h2);
    u_cpu.ee_read(9'h000, r);
    chk(r, 32'(mem[0]));
    $display("clock enable done");
    a = 9'($urandom_range(511, 0));
    d = 8'($urandom);
    mem[a] = d;
    u_cpu.ee_write(a, d);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    u_cpu.io_rd(6'h1c, r);
    chk(r, 32'h2);
    u_cpu.wait_idle();
    u_cpu.ee_read(a, r);
    chk(r, 32'(mem[a]));
    $display("reset mid write done");
    d = ~d;
    mem[a] = d;
    u_cpu.ee_write(a, d);
    pd_req <= 1'b1;
    u_cpu.wait_idle();
    repeat (2) @(posedge pclk);
    chk({31'h0, osc_keep_running}, 32'h1);
    chk({31'h0, pd_entered}, 32'h0);
    pd_req <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({31'h0, osc_keep_running}, 32'h0);
    pd_req <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({31'h0, pd_entered}, 32'h1);
    pd_req <= 1'b0;
    u_cpu.ee_read(a, r);
    chk(r, 32'(mem[a]));
    $display("power-down done");
    u_cpu.xfer(1'b1, 12'h4f8, 32'h3c, 1'b0, r, e);
    u_cpu.io_rd(6'h1e, r);
    chk(r, 32'h3c);
    u_cpu.xfer(1'b0, 12'h57c, 32'h0, 1'b0, r, e);
    chk({31'h0, e}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      u_cpu.xfer(1'b1, eadr[i], edat[i], 1'b0, r, e);
      chk({31'h0, e}, 32'h1);
    end
    u_cpu.io_rd(6'h1e, r);
    chk(r, 32'h3c);
    u_cpu.xfer(1'b0, 12'h0fc, 32'h0, 1'b0, r, e);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h0);
    $display("decode done");
    u_cpu.xfer(1'b1, 12'h800, 32'h0001e, 1'b0, r, e);
    u_cpu.io_rd(6'h1e, r);
    chk(r, 32'h3d);
    u_cpu.xfer(1'b1, 12'h800, 32'h2021e, 1'b0, r, e);
    u_cpu.xfer(1'b0, 12'h800, 32'h0, 1'b0, r, e);
    chk(r, 32'h1);
    u_cpu.io_rd(6'h1b, r);
    chk(r, 32'h1);
    u_cpu.xfer(1'b1, 12'h800, 32'h1051b, 1'b0, r, e);
    u_cpu.io_rd(6'h1b, r);
    chk(r, 32'h0);
    $display("bit ops done");
    test_done();
  end
endmodule : eeio_top_bench
